// [tb/regflt_top_tb.sv]
// self-checking bench for the regulator fault interrupt block
// assumes: design files and consts header on the include path; APB slave answers in access phase
`timescale 1ns/10ps
`default_nettype none
`include "regflt_consts.svh"
module regflt_top_tb;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        CLK, RSTN, CE, PSEL, PENABLE, PWRITE, PWR_UP_DONE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdata;
  logic        PREADY, PSLVERR, IRQ, perr;
  logic [3:0]  ILIM_IN, SHORT_IN, RESID_IN, OV_IN, UV_IN, OUT_LOW_IN, REG_ENABLE, SEQ_TRIG;
  logic [3:0]  trig_seen = 4'h0;
  logic        clr_tog = 1'b0;
  logic        clr_ack = 1'b0;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  // short ramp keeps the refused-clear wait brief
  regflt_top #(.NREG(4), .RAMP_CYCLES(3)) i_dut (
    .CLK(CLK), .RSTN(RSTN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ILIM_IN(ILIM_IN), .SHORT_IN(SHORT_IN), .RESID_IN(RESID_IN), .OV_IN(OV_IN), .UV_IN(UV_IN),
    .OUT_LOW_IN(OUT_LOW_IN), .PWR_UP_DONE(PWR_UP_DONE), .REG_ENABLE(REG_ENABLE),
    .SEQ_TRIG(SEQ_TRIG), .IRQ(IRQ));

  // ----------------------------------------
  // clock, trigger capture, hang guard
  // ----------------------------------------
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  // triggers are one-cycle pulses: sticky copy taken mid-cycle, away from the launching edge;
  // the main thread restarts it by a toggle, so only this process writes it
  always @(negedge CLK) begin
    trig_seen <= (clr_tog != clr_ack) ? SEQ_TRIG : (trig_seen | SEQ_TRIG);
    clr_ack   <= clr_tog;
  end
  // hang guard
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask : chk

  // one APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= wr; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rdata = PRDATA;
    perr = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // sync latency plus margin before looking at flags
  task automatic settle();
    repeat (8) @(posedge CLK);
  endtask : settle

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    RSTN = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 12'h000; PWDATA = 32'h0;
    ILIM_IN = 4'h0; SHORT_IN = 4'h0; RESID_IN = 4'h0; OV_IN = 4'h0; UV_IN = 4'h0;
    OUT_LOW_IN = 4'h0; PWR_UP_DONE = 1'b1; CE = 1'b1;
    repeat (16) @(posedge CLK);
    RSTN <= 1'b1;
    // reset view and a refused unmapped access
    rd(`ADDR_SUMMARY); chk(rdata, 32'h0);
    rd(`ADDR_TRIGSEL); chk(rdata, 32'h0000_000F);
    rd(12'hFFC); chk(rdata, 32'h0); chk({31'h0, perr}, 32'h1);
    wr(`ADDR_REGEN, 32'hF); wr(`ADDR_CTRL, 32'h0); wr(`ADDR_IRQ_EN, 32'h11);
    // current limit, escalation off: flag only, clear refused while active
    clr_tog = ~clr_tog;
    @(posedge CLK) ILIM_IN <= 4'h1;
    settle();
    rd(`ADDR_PAIR_A); chk(rdata, 32'h08);
    chk(trig_seen, 4'h0);
    rd(`ADDR_SUMMARY); chk(rdata, 32'h01);
    chk(IRQ, 1'b1);
    wr(`ADDR_PAIR_A, 32'h08); rd(`ADDR_PAIR_A); chk(rdata, 32'h08);
    @(posedge CLK) ILIM_IN <= 4'h0;
    settle();
    wr(`ADDR_PAIR_A, 32'h08); rd(`ADDR_PAIR_A); chk(rdata, 32'h0);
    wr(`ADDR_IRQ_CLR, 32'h1F); settle(); chk(IRQ, 1'b0);
    // current limit, escalation on: trigger on regulator 1, upper nibble
    wr(`ADDR_CTRL, 32'h1);
    clr_tog = ~clr_tog;
    @(posedge CLK) ILIM_IN <= 4'h2;
    settle();
    rd(`ADDR_PAIR_A); chk(rdata, 32'h80);
    chk(trig_seen, 4'h2);
    @(posedge CLK) ILIM_IN <= 4'h0;
    settle();
    wr(`ADDR_PAIR_A, 32'h80);
    // overvoltage on regulator 0: live bit, trigger, held clear
    clr_tog = ~clr_tog;
    @(posedge CLK) OV_IN <= 4'h1;
    settle();
    rd(`ADDR_PAIR_A); chk(rdata, 32'h01);
    rd(`ADDR_LIVE_A); chk(rdata, 32'h01);
    chk(trig_seen, 4'h1);
    wr(`ADDR_PAIR_A, 32'h01); rd(`ADDR_PAIR_A); chk(rdata, 32'h01);
    @(posedge CLK) OV_IN <= 4'h0;
    settle();
    rd(`ADDR_LIVE_A); chk(rdata, 32'h0);
    wr(`ADDR_PAIR_A, 32'h01); rd(`ADDR_PAIR_A); chk(rdata, 32'h0);
    // undervoltage on regulator 3 lands in pair b bit 5
    clr_tog = ~clr_tog;
    @(posedge CLK) UV_IN <= 4'h8;
    settle();
    rd(`ADDR_PAIR_B); chk(rdata, 32'h20);
    chk(trig_seen, 4'h8);
    rd(`ADDR_SUMMARY); chk(rdata, 32'h02);
    wr(`ADDR_PAIR_B, 32'h20); rd(`ADDR_PAIR_B); chk(rdata, 32'h20);
    @(posedge CLK) UV_IN <= 4'h0;
    settle();
    wr(`ADDR_PAIR_B, 32'h20); rd(`ADDR_PAIR_B); chk(rdata, 32'h0);
    wr(`ADDR_IRQ_CLR, 32'h1F);
    // masked event: flag set, summary and interrupt quiet until unmasked
    wr(`ADDR_MASK_A, 32'h01);
    @(posedge CLK) OV_IN <= 4'h1;
    settle();
    @(posedge CLK) OV_IN <= 4'h0;
    settle();
    rd(`ADDR_PAIR_A); chk(rdata, 32'h01);
    rd(`ADDR_SUMMARY); chk(rdata, 32'h0);
    chk(IRQ, 1'b0);
    wr(`ADDR_MASK_A, 32'h0); settle();
    rd(`ADDR_SUMMARY); chk(rdata, 32'h01);
    chk(IRQ, 1'b1);
    wr(`ADDR_PAIR_A, 32'h01); rd(`ADDR_SUMMARY); chk(rdata, 32'h0);
    wr(`ADDR_IRQ_CLR, 32'h1F); settle(); chk(IRQ, 1'b0);
    // short on regulator 1 disables it; clear refused while output stays low
    clr_tog = ~clr_tog;
    @(posedge CLK) SHORT_IN <= 4'h2;
    settle();
    @(posedge CLK) SHORT_IN <= 4'h0;
    settle();
    chk(REG_ENABLE, 4'hD);
    chk(trig_seen, 4'h2);
    rd(`ADDR_PAIR_A); chk(rdata, 32'h40);
    wr(`ADDR_REGEN, 32'hF);
    @(posedge CLK) OUT_LOW_IN <= 4'h2;
    repeat (12) @(posedge CLK);
    wr(`ADDR_PAIR_A, 32'h40); rd(`ADDR_PAIR_A); chk(rdata, 32'h40);
    @(posedge CLK) OUT_LOW_IN <= 4'h0;
    settle();
    wr(`ADDR_PAIR_A, 32'h40); rd(`ADDR_PAIR_A); chk(rdata, 32'h0);
    // residual on regulator 2: ignored when unselected, hidden until power-up
    wr(`ADDR_REGEN, 32'hF);
    clr_tog = ~clr_tog;
    @(posedge CLK) RESID_IN <= 4'h4;
    settle();
    rd(`ADDR_PAIR_B); chk(rdata, 32'h0);
    chk(REG_ENABLE, 4'hF); chk(trig_seen, 4'h0);
    @(posedge CLK) PWR_UP_DONE <= 1'b0;
    wr(`ADDR_RVSEL, 32'h4);
    settle();
    chk(REG_ENABLE, 4'hB); chk(trig_seen, 4'h4);
    rd(`ADDR_PAIR_B); chk(rdata, 32'h0);
    @(posedge CLK) RESID_IN <= 4'h0;
    settle();
    rd(`ADDR_PAIR_B); chk(rdata, 32'h0);
    @(posedge CLK) PWR_UP_DONE <= 1'b1;
    settle();
    rd(`ADDR_PAIR_B); chk(rdata, 32'h04);
    wr(`ADDR_PAIR_B, 32'h04); rd(`ADDR_PAIR_B); chk(rdata, 32'h0);
    // group routing: regulator 1 moved to group 1, which is then switched off
    wr(`ADDR_GRPSEL, 32'h04); wr(`ADDR_TRIGSEL, 32'h02);
    clr_tog = ~clr_tog;
    @(posedge CLK) OV_IN <= 4'h2;
    settle();
    chk(trig_seen, 4'h2);
    @(posedge CLK) OV_IN <= 4'h0;
    settle();
    wr(`ADDR_TRIGSEL, 32'h0D);
    clr_tog = ~clr_tog;
    @(posedge CLK) OV_IN <= 4'h2;
    settle();
    chk(trig_seen, 4'h0);
    @(posedge CLK) OV_IN <= 4'h0;
    settle();
    wr(`ADDR_PAIR_A, 32'h10); rd(`ADDR_PAIR_A); chk(rdata, 32'h0);
    // clock enable low: a write and a fault event are both lost
    @(posedge CLK) CE <= 1'b0;
    wr(`ADDR_MASK_B, 32'hFF);
    @(posedge CLK) OV_IN <= 4'h2;
    settle();
    @(posedge CLK) OV_IN <= 4'h0;
    settle();
    @(posedge CLK) CE <= 1'b1;
    settle();
    rd(`ADDR_MASK_B); chk(rdata, 32'h0);
    rd(`ADDR_PAIR_A); chk(rdata, 32'h0);
    give_verdict();
  end
endmodule : regflt_top_tb
`default_nettype wire

// [verilog/rail_flags.sv]
// flags of one regulator: four sticky write-one-to-clear bits
// assumes: condition inputs already synchronised; clear is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
`include "regflt_consts.svh"
module rail_flags #(
  parameter int RAMP_CYCLES = `RAMP_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       ilim,
  input  wire logic       shrt,
  input  wire logic       resid,
  input  wire logic       ov,
  input  wire logic       uv,
  input  wire logic       out_low,
  input  wire logic       reg_on,
  input  wire logic       resid_en,
  input  wire logic       esc_en,
  input  wire logic       pwr_up_done,
  input  wire logic [3:0] clr,
  output logic      [3:0] flags,
  output logic      [3:0] visible,
  output logic            trig,
  output logic            disable_req
);
  // ------------------------------------------------------------
  // ramp timer and residual visibility
  // ------------------------------------------------------------
  logic [15:0]         ramp_r;
  regflt_pkg::rv_state_e rv_r;
  logic                sc_hold;
  logic                resid_hit;
  logic [3:0]          set;
  logic [3:0]          hold;

  assign resid_hit = resid & resid_en;
  // ramp counter restarts whenever the regulator is switched off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_r <= 16'h0000;
    end else if (ce) begin
      if (!reg_on) ramp_r <= 16'h0000;
      else if (ramp_r < 16'(RAMP_CYCLES)) ramp_r <= ramp_r + 16'h0001;
    end
  end
  assign sc_hold = reg_on & out_low & (ramp_r >= 16'(RAMP_CYCLES));

  // residual-set flag stays hidden until recovery and a good power-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rv_r <= regflt_pkg::RV_IDLE;
    end else if (ce) begin
      case (rv_r)
        regflt_pkg::RV_IDLE:  if (resid_hit) rv_r <= regflt_pkg::RV_WAIT;
        regflt_pkg::RV_WAIT:  if (!resid && pwr_up_done) rv_r <= regflt_pkg::RV_SHOWN;
        regflt_pkg::RV_SHOWN: begin
          // a fresh residual hit hides the flag again until the next recovery
          if (resid_hit) rv_r <= regflt_pkg::RV_WAIT;
          else if (!flags[`FLD_SC]) rv_r <= regflt_pkg::RV_IDLE;
        end
        default:              rv_r <= regflt_pkg::RV_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // sticky flags: set beats clear, live condition blocks clear
  // ------------------------------------------------------------
  assign set  = {ilim, shrt | resid_hit, uv, ov};
  assign hold = {ilim, sc_hold, uv, ov};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= 4'h0;
    end else if (ce) begin
      flags <= set | hold & flags | flags & ~clr;
    end
  end
  always_comb begin
    visible = flags;
    if (rv_r == regflt_pkg::RV_WAIT) visible[`FLD_SC] = 1'b0;
  end

  // trigger pulses on the rising edge of the OR of all triggering events
  logic trig_src;
  logic trig_d_r;
  assign trig_src = (ilim & esc_en) | shrt | resid_hit | ov | uv;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_d_r    <= 1'b0;
      trig        <= 1'b0;
      disable_req <= 1'b0;
    end else if (ce) begin
      trig_d_r    <= trig_src;
      trig        <= trig_src & ~trig_d_r;
      disable_req <= shrt | resid_hit;
    end
  end

  property p_ilim_held;
    @(posedge clk) disable iff (!rst_n) (ce && ilim) |=> flags[`FLD_ILIM];
  endproperty
  a_ilim_held: assert property (p_ilim_held) else $error("ilim flag not held");
  property p_ov_held;
    @(posedge clk) disable iff (!rst_n) (ce && ov) |=> flags[`FLD_OV];
  endproperty
  a_ov_held: assert property (p_ov_held) else $error("ov flag not held");
  property p_uv_held;
    @(posedge clk) disable iff (!rst_n) (ce && uv) |=> flags[`FLD_UV];
  endproperty
  a_uv_held: assert property (p_uv_held) else $error("uv flag not held");
  property p_sc_disable;
    @(posedge clk) disable iff (!rst_n) (ce && shrt) |=> (disable_req && flags[`FLD_SC]);
  endproperty
  a_sc_disable: assert property (p_sc_disable) else $error("short not acted on");
  property p_resid_off;
    @(posedge clk) disable iff (!rst_n) (ce && resid && !resid_en && !shrt) |=> !disable_req;
  endproperty
  a_resid_off: assert property (p_resid_off) else $error("residual acted while off");
  property p_ilim_notrig;
    @(posedge clk) disable iff (!rst_n)
      (ce && !esc_en && !shrt && !resid_hit && !ov && !uv && !trig_d_r) |=> !trig;
  endproperty
  a_ilim_notrig: assert property (p_ilim_notrig) else $error("trigger without cause");
  property p_hidden;
    @(posedge clk) disable iff (!rst_n) (ce && resid_hit) |=> !visible[`FLD_SC];
  endproperty
  a_hidden: assert property (p_hidden) else $error("residual flag shown early");
endmodule : rail_flags
`default_nettype wire

// [verilog/regflt_consts.svh]
// constants for the regulator fault interrupt block
// assumes: included by bare name; one 25 MHz clock domain
//
// Summary of operation
// - current-limit trip with escalation on sets flag and fires selected sequencer trigger
// - escalation off: current-limit trip sets flag only, no trigger
// - current-limit flag clears on write one, but not while limit still active
// - short circuit disables regulator, sets short flag, fires trigger; no mask or live
// - short flag clear refused while enabled and output low after ramp time
// - residual violation with check enabled acts like short; disabled does nothing
// - residual-set short flag reads zero until condition gone and power-up completed
// - overvoltage sets flag, has mask and live bits, fires selected trigger
// - overvoltage flag clears on write one, held while condition present
// - pair registers hold four flags per regulator; summary and top bit above
// - undervoltage sets flag with mask and live, fires trigger, held while present
`ifndef REGFLT_CONSTS_SVH
`define REGFLT_CONSTS_SVH
`define ADDR_SUMMARY   12'h000
`define ADDR_PAIR_A    12'h004
`define ADDR_PAIR_B    12'h008
`define ADDR_MASK_A    12'h00C
`define ADDR_MASK_B    12'h010
`define ADDR_LIVE_A    12'h014
`define ADDR_LIVE_B    12'h018
`define ADDR_CTRL      12'h01C
`define ADDR_GRPSEL    12'h020
`define ADDR_TRIGSEL   12'h024
`define ADDR_RVSEL     12'h028
`define ADDR_REGEN     12'h02C
`define ADDR_IRQ_STAT  12'h030
`define ADDR_IRQ_EN    12'h034
`define ADDR_IRQ_CLR   12'h038
// field positions inside one regulator nibble
`define FLD_OV    0
`define FLD_UV    1
`define FLD_SC    2
`define FLD_ILIM  3
`define CTRL_ESC_BIT 0
`define RAMP_NS   1000
`define CLK_NS    40
`define RAMP_CYC  ((`RAMP_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// [verilog/regflt_pkg.sv]
// types shared by the regulator fault interrupt block
// assumes: nothing beyond the consts header
package regflt_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [2:0] {
    RV_IDLE   = 3'b001,
    RV_WAIT   = 3'b010,
    RV_SHOWN  = 3'b100
  } rv_state_e;
endpackage : regflt_pkg

// [verilog/regflt_top.sv]
// regulator fault interrupt block with APB register slave
// assumes: fault inputs are asynchronous pins; APB on CLK; RSTN async low
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "regflt_consts.svh"
module regflt_top #(
  parameter int NREG        = 4,
  parameter int RAMP_CYCLES = `RAMP_CYC
) (
  input  wire logic            CLK,
  input  wire logic            RSTN,
  input  wire logic            CE,
  input  wire logic            PSEL,
  input  wire logic            PENABLE,
  input  wire logic            PWRITE,
  input  wire logic [11:0]     PADDR,
  input  wire logic [31:0]     PWDATA,
  output logic      [31:0]     PRDATA,
  output logic                 PREADY,
  output logic                 PSLVERR,
  input  wire logic [NREG-1:0] ILIM_IN,
  input  wire logic [NREG-1:0] SHORT_IN,
  input  wire logic [NREG-1:0] RESID_IN,
  input  wire logic [NREG-1:0] OV_IN,
  input  wire logic [NREG-1:0] UV_IN,
  input  wire logic [NREG-1:0] OUT_LOW_IN,
  input  wire logic            PWR_UP_DONE,
  output logic      [NREG-1:0] REG_ENABLE,
  output logic      [NREG-1:0] SEQ_TRIG,
  output logic                 IRQ
);
  // ------------------------------------------------------------
  // pin synchronisers: first stage read only by the second
  // ------------------------------------------------------------
  localparam int NS = 6 * NREG + 1;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s1_r <= '0;
      s2_r <= '0;
    end else if (CE) begin
      s1_r <= {PWR_UP_DONE, OUT_LOW_IN, UV_IN, OV_IN, RESID_IN, SHORT_IN, ILIM_IN};
      s2_r <= s1_r;
    end
  end
  logic [NREG-1:0] ilim_s, shrt_s, resid_s, ov_s, uv_s, low_s;
  logic            pud_s;
  assign {pud_s, low_s, uv_s, ov_s, resid_s, shrt_s, ilim_s} = s2_r;

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  logic [7:0]      mask_a_r, mask_b_r;
  logic [7:0]      ctrl_r;
  logic [7:0]      grpsel_r;   // two bits per regulator: sequencer group
  logic [3:0]      trigsel_r;  // which groups raise a trigger
  logic [NREG-1:0] rvsel_r;
  logic [NREG-1:0] regen_r;
  logic [3:0]      irq_en_r;
  logic [3:0]      irq_st_r;
  logic            wr_acc;
  logic            addr_ok;

  assign wr_acc = PSEL & PENABLE & PWRITE & CE;
  assign PREADY  = 1'b1; // zero wait states keeps the master simple
  always_comb begin
    case (PADDR)
      `ADDR_SUMMARY, `ADDR_PAIR_A, `ADDR_PAIR_B, `ADDR_MASK_A, `ADDR_MASK_B,
      `ADDR_LIVE_A, `ADDR_LIVE_B, `ADDR_CTRL, `ADDR_GRPSEL, `ADDR_TRIGSEL,
      `ADDR_RVSEL, `ADDR_REGEN, `ADDR_IRQ_STAT, `ADDR_IRQ_EN, `ADDR_IRQ_CLR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;

  // control registers written by software
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mask_a_r  <= 8'h00;
      mask_b_r  <= 8'h00;
      ctrl_r    <= 8'h00;
      grpsel_r  <= 8'h00;
      trigsel_r <= 4'hF;
      rvsel_r   <= '0;
      irq_en_r  <= 4'h0;
    end else if (wr_acc) begin
      case (PADDR)
        `ADDR_MASK_A:  mask_a_r  <= PWDATA[7:0];
        `ADDR_MASK_B:  mask_b_r  <= PWDATA[7:0];
        `ADDR_CTRL:    ctrl_r    <= PWDATA[7:0];
        `ADDR_GRPSEL:  grpsel_r  <= PWDATA[7:0];
        `ADDR_TRIGSEL: trigsel_r <= PWDATA[3:0];
        `ADDR_RVSEL:   rvsel_r   <= PWDATA[NREG-1:0];
        `ADDR_IRQ_EN:  irq_en_r  <= PWDATA[3:0];
        default:       ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // per-regulator flag slices
  // ------------------------------------------------------------
  logic [4*NREG-1:0] flags_all, vis_all, clr_all;
  logic [NREG-1:0]   trig_raw, dis_req;
  logic [7:0]        w1c_a, w1c_b;
  assign w1c_a = (wr_acc && PADDR == `ADDR_PAIR_A) ? PWDATA[7:0] : 8'h00;
  assign w1c_b = (wr_acc && PADDR == `ADDR_PAIR_B) ? PWDATA[7:0] : 8'h00;
  assign clr_all = {w1c_b, w1c_a};

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_rail
      rail_flags #(.RAMP_CYCLES(RAMP_CYCLES)) u_rail (
        .clk         (CLK),
        .rst_n       (RSTN),
        .ce          (CE),
        .ilim        (ilim_s[g]),
        .shrt        (shrt_s[g]),
        .resid       (resid_s[g]),
        .ov          (ov_s[g]),
        .uv          (uv_s[g]),
        .out_low     (low_s[g]),
        .reg_on      (regen_r[g]),
        .resid_en    (rvsel_r[g]),
        .esc_en      (ctrl_r[`CTRL_ESC_BIT]),
        .pwr_up_done (pud_s),
        .clr         (clr_all[4*g +: 4]),
        .flags       (flags_all[4*g +: 4]),
        .visible     (vis_all[4*g +: 4]),
        .trig        (trig_raw[g]),
        .disable_req (dis_req[g])
      );
    end
  endgenerate

  // regulator enables: software turns on, a fault turns off
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      regen_r <= '0;
    end else if (CE) begin
      if (wr_acc && PADDR == `ADDR_REGEN) regen_r <= PWDATA[NREG-1:0] & ~dis_req;
      else                                 regen_r <= regen_r & ~dis_req;
    end
  end
  assign REG_ENABLE = regen_r;

  // sequencer trigger of each regulator stays on its own bit, gated by the trigsel bit of its chosen group
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SEQ_TRIG <= '0;
    end else if (CE) begin
      for (int i = 0; i < NREG; i++) begin
        SEQ_TRIG[i] <= trig_raw[i] & trigsel_r[grpsel_r[2*i +: 2]];
      end
    end
  end

  // ------------------------------------------------------------
  // hierarchy: pair registers, summary, top bit
  // ------------------------------------------------------------
  logic [7:0] pair_a, pair_b, live_a, live_b;
  logic       sum_a, sum_b, top_sum;
  assign pair_a = vis_all[7:0];
  assign pair_b = vis_all[15:8];
  // short bit has no mask; masked flags never feed the summaries
  assign sum_a = |(pair_a & ~(mask_a_r & 8'hBB));
  assign sum_b = |(pair_b & ~(mask_b_r & 8'hBB));
  assign top_sum = sum_a | sum_b;
  assign live_a = {ilim_s[1], 1'b0, uv_s[1], ov_s[1], ilim_s[0], 1'b0, uv_s[0], ov_s[0]};
  assign live_b = {ilim_s[3], 1'b0, uv_s[3], ov_s[3], ilim_s[2], 1'b0, uv_s[2], ov_s[2]};

  // ------------------------------------------------------------
  // interrupt status: sticky, write-only clear, set wins
  // ------------------------------------------------------------
  logic [3:0] irq_ev;
  logic [3:0] irq_clr;
  logic       sum_a_d_r, sum_b_d_r;
  logic [NREG-1:0] dis_d_r;
  assign irq_clr = (wr_acc && PADDR == `ADDR_IRQ_CLR) ? PWDATA[3:0] : 4'h0;
  assign irq_ev  = {|SEQ_TRIG, |(dis_req & ~dis_d_r), sum_b & ~sum_b_d_r, sum_a & ~sum_a_d_r};
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_st_r  <= 4'h0;
      sum_a_d_r <= 1'b0;
      sum_b_d_r <= 1'b0;
      dis_d_r   <= '0;
    end else if (CE) begin
      irq_st_r  <= irq_ev | (irq_st_r & ~irq_clr);
      sum_a_d_r <= sum_a;
      sum_b_d_r <= sum_b;
      dis_d_r   <= dis_req;
    end
  end
  assign IRQ = |(irq_st_r & irq_en_r);

  // ------------------------------------------------------------
  // read data: registered on the setup cycle
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= 32'h00000000;
    end else if (CE && PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        `ADDR_SUMMARY:   PRDATA <= {30'h0, sum_b, sum_a};
        `ADDR_PAIR_A:    PRDATA <= {24'h0, pair_a};
        `ADDR_PAIR_B:    PRDATA <= {24'h0, pair_b};
        `ADDR_MASK_A:    PRDATA <= {24'h0, mask_a_r};
        `ADDR_MASK_B:    PRDATA <= {24'h0, mask_b_r};
        `ADDR_LIVE_A:    PRDATA <= {24'h0, live_a};
        `ADDR_LIVE_B:    PRDATA <= {24'h0, live_b};
        `ADDR_CTRL:      PRDATA <= {24'h0, ctrl_r};
        `ADDR_GRPSEL:    PRDATA <= {24'h0, grpsel_r};
        `ADDR_TRIGSEL:   PRDATA <= {28'h0, trigsel_r};
        `ADDR_RVSEL:     PRDATA <= {28'h0, rvsel_r};
        `ADDR_REGEN:     PRDATA <= {28'h0, regen_r};
        `ADDR_IRQ_STAT:  PRDATA <= {27'h0, top_sum, irq_st_r};
        `ADDR_IRQ_EN:    PRDATA <= {28'h0, irq_en_r};
        default:         PRDATA <= 32'h00000000;
      endcase
    end
  end

  property p_top_follows;
    @(posedge CLK) disable iff (!RSTN) (sum_a || sum_b) |-> top_sum;
  endproperty
  a_top_follows: assert property (p_top_follows) else $error("top bit missing");
  property p_mask_blocks;
    @(posedge CLK) disable iff (!RSTN)
      (pair_a == 8'h01 && mask_a_r[0]) |-> !sum_a;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked flag reached summary");
endmodule : regflt_top
`default_nettype wire
